//--- design/lcd_dither.sv
`timescale 1ns/1ps
`include "lcd_params.svh"
// space/time dither of the three guns of one pixel
module lcd_dither
    import lcd_pkg::*;
(
    input  wire pix_t       pix,
    input  wire logic       mono,
    output logic [2:0]      dots
);
    // on-threshold out of a 90-phase cycle; 90 is the lcm of 9, 5, 15 and 2
    function automatic logic [6:0] on_limit(input logic [3:0] code);
        case (code)
            4'h0: on_limit = 7'h00;
            4'h1: on_limit = 7'h0A;
            4'h2: on_limit = 7'h12;
            4'h3: on_limit = 7'h18;
            4'h4: on_limit = 7'h1E;
            4'h5: on_limit = 7'h24;
            4'h6: on_limit = 7'h28;
            4'h7: on_limit = 7'h2D;
            4'h8: on_limit = 7'h32;
            4'h9: on_limit = 7'h36;
            4'hA: on_limit = 7'h3C;
            4'hB: on_limit = 7'h42;
            4'hC: on_limit = 7'h48;
            4'hD: on_limit = 7'h50;
            default: on_limit = 7'h5A; // two top codes both always on
        endcase
    endfunction

    // each gun offset in phase so colors do not flash in step
    for (genvar g = 0; g < 3; g++) begin : g_gun
        logic [3:0] gun;
        logic [7:0] sum;
        logic [6:0] ph;
        assign gun  = (g == 0) ? pix.r : (g == 1) ? pix.g : pix.b;
        assign sum  = {1'b0, pix.phase} + 8'(g * `GUN_STEP);
        assign ph   = (sum >= `DITH_PERIOD) ? 7'(sum - `DITH_PERIOD) : sum[6:0];
        // dot lit while phase below threshold, 1 means on
        assign dots[g] = (mono && g != 2) ? 1'b0 : (ph < on_limit(gun));
    end
endmodule

//--- design/lcd_params.svh
// constants for the lcd output block: offsets, fields, resets, timing counts
//
// Contract
// - 4-bit gun picks 15 levels; 1110,1111 full
// - panel data active high: 1 lights pixel
// - gray by on/off rates over space, time
// - codes 0-7: 0,1/9,1/5,4/15,3/9,2/5,4/9,1/2
// - codes 8-13: 5/9,3/5,6/9,11/15,4/5,8/9
// - color passive dithers r,g,b like mono
// - tft pixel clock toggles while lcd enabled
// - tft bias pin is data output enable
// - tft line pin hsync, frame pin vsync
// - tft one pixel/clock; passive 4,8,2-2/3; code has no 8 pixel/clock mode, mono is 4 only
// - unshared: lcd and vga separate dma channels
// - shared: each dma word into both fifos
// - shared: request only when both fifos roomy
// - lcd and vga enables in one register
// - control bit 4: 0 passive, 1 tft
// - mono passive uses blue gun only
`ifndef LCD_PARAMS_SVH
`define LCD_PARAMS_SVH

`define CTRL_OFS      8'h00
`define STAT_OFS      8'h04
`define CTRL_RST      5'h00

`define CTL_LCD_EN    0
`define CTL_MONO      3
`define CTL_TFT       4
`define CTL_VGA_EN    8
`define CTL_SHARE     11

`define ST_REQ        8
`define ST_UNDER      9
`define ST_OVER       10

`define LFIFO_DEPTH   6'h20
`define LFIFO_AW      5
`define REQ_WORDS     6'h08

`define H_ACT         11'h280
`define H_FP          11'h010
`define H_SYNC        11'h060
`define H_BP          11'h030
`define V_ACT         10'h1E0
`define V_FP          10'h00A
`define V_SYNC        10'h002
`define V_BP          10'h021

`define DITH_PERIOD   8'h5A
`define DX_STEP       7'h25
`define DY_STEP       7'h35
`define DF_STEP       7'h01
`define GUN_STEP      8'h1E

`endif

//--- design/lcd_pkg.sv
// types shared by the lcd output block
package lcd_pkg;
    // one pixel on its way to the panel, with its dither phase
    typedef struct packed {
        logic [3:0] r;
        logic [3:0] g;
        logic [3:0] b;
        logic [6:0] phase;
    } pix_t;

    // software control bits
    typedef struct packed {
        logic flat_panel_enable;
        logic panel_monochrome_select;
        logic panel_active_matrix_select;
        logic monitor_output_enable;
        logic dual_fifo_feed_select;
    } ctrl_t;

    typedef enum logic [3:0] {
        h_act  = 4'b0001,
        h_fp   = 4'b0010,
        h_sync = 4'b0100,
        h_bp   = 4'b1000
    } hstate_t;
endpackage

//--- design/lcd_skid.sv
`timescale 1ns/1ps
// two-entry pixel buffer between unpacker and panel side
module lcd_skid
    import lcd_pkg::*;
(
    input  wire logic   core_clk,
    input  wire logic   rst_n,
    input  wire logic   flush,
    input  wire logic   in_valid,
    output logic        in_ready,
    input  wire pix_t   in_pix,
    output logic        out_valid,
    input  wire logic   out_ready,
    output pix_t        out_pix
);
    pix_t       slot_reg [0:1];
    logic       wp_reg;
    logic       rp_reg;
    logic [1:0] cnt_reg;
    logic       wr;
    logic       rd;

    assign in_ready  = (cnt_reg != 2'h2);
    assign out_valid = (cnt_reg != 2'h0);
    assign out_pix   = slot_reg[rp_reg];
    assign wr        = in_valid && in_ready;
    assign rd        = out_valid && out_ready;

    // slot storage needs no reset, count says what is valid
    always_ff @(posedge core_clk) begin
        if (wr) begin
            slot_reg[wp_reg] <= in_pix;
        end
    end

    // pointers and fill count
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_reg  <= 1'b0;
            rp_reg  <= 1'b0;
            cnt_reg <= 2'h0;
        end else if (flush) begin
            wp_reg  <= 1'b0;
            rp_reg  <= 1'b0;
            cnt_reg <= 2'h0;
        end else begin
            wp_reg  <= wp_reg ^ wr;
            rp_reg  <= rp_reg ^ rd;
            cnt_reg <= 2'(cnt_reg + {1'b0, wr} - {1'b0, rd});
        end
    end
endmodule

//--- design/lcd_top.sv
`timescale 1ns/1ps
`include "lcd_params.svh"
// lcd output side: control registers, dma fifo, dither, panel timing and pins
module lcd_top
    import lcd_pkg::*;
(
    input  wire logic           core_clk,
    input  wire logic           rst_n,
    input  wire logic [7:0]     reg_addr,
    input  wire logic [31:0]    reg_wdata,
    input  wire logic           reg_wr,
    input  wire logic           reg_rd,
    output logic [31:0]         reg_rdata,
    output logic                dma_req,
    input  wire logic           dma_valid,
    input  wire logic [31:0]    dma_data,
    input  wire logic [5:0]     vga_fifo_free,
    output logic                vga_fifo_wr,
    output logic [31:0]         vga_fifo_data,
    output logic                flat_panel_enable,
    output logic                monitor_output_enable,
    input  wire logic           pix_clk_in,
    output logic                panel_pclk,
    output logic                panel_line_clk,
    output logic                panel_frame_clk,
    output logic                panel_bias_output_enable_pin,
    output logic [11:0]         panel_data
);
    ctrl_t                  ctrl_reg;
    logic [31:0]            ctrl_word, stat_word, rd_word, rdata_reg;
    logic                   under_reg, over_reg, en, tft, mono, share;
    logic [31:0]            fifo_mem [0:`LFIFO_DEPTH-1];
    logic [`LFIFO_AW-1:0]   wr_ptr_reg, rd_ptr_reg;
    logic [`LFIFO_AW:0]     level_reg;
    logic [5:0]             lcd_free;
    logic                   fifo_full, fifo_wr, word_pop, vga_wr_reg;
    logic [31:0]            vga_data_reg, head_word;
    logic                   half_reg;
    logic [9:0]             x_cnt_reg, y_cnt_reg, v_cnt_reg;
    logic [6:0]             ph_reg, row_ph_reg, frm_ph_reg;
    pix_t                   pix_in, sk_pix;
    logic                   pix_valid, pix_fire, skid_in_ready, sk_valid, sk_take;
    logic [2:0]             dots, new_bits;
    logic                   pclk_s1_reg, pclk_s2_reg, pclk_s3_reg, tick;
    hstate_t                h_state_reg;
    logic [10:0]            h_cnt_reg, step, line_units;
    logic                   v_act, vsync, in_act, frm_bias_reg;
    logic [15:0]            acc_reg, after_acc;
    logic [4:0]             acc_cnt_reg, width, after_cnt;
    logic                   consume, avail, push, underrun;
    logic [7:0]             emit_mask;
    logic                   pclk_reg, line_reg, frame_reg, bias_reg;
    logic [11:0]            data_reg;

    assign en    = ctrl_reg.flat_panel_enable;
    assign tft   = ctrl_reg.panel_active_matrix_select;
    assign mono  = ctrl_reg.panel_monochrome_select;
    assign share = ctrl_reg.dual_fifo_feed_select;
    assign flat_panel_enable     = ctrl_reg.flat_panel_enable;
    assign monitor_output_enable = ctrl_reg.monitor_output_enable;

    // both enables live in one word so one write starts both paths
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `CTRL_RST;
        end else if (reg_wr && reg_addr == `CTRL_OFS) begin
            ctrl_reg.flat_panel_enable          <= reg_wdata[`CTL_LCD_EN];
            ctrl_reg.panel_monochrome_select    <= reg_wdata[`CTL_MONO];
            ctrl_reg.panel_active_matrix_select <= reg_wdata[`CTL_TFT];
            ctrl_reg.monitor_output_enable      <= reg_wdata[`CTL_VGA_EN];
            ctrl_reg.dual_fifo_feed_select      <= reg_wdata[`CTL_SHARE];
        end
    end

    // sticky error flags, write one to clear; a new event beats the clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            under_reg <= 1'b0;
            over_reg  <= 1'b0;
        end else begin
            if (underrun) begin
                under_reg <= 1'b1;
            end else if (reg_wr && reg_addr == `STAT_OFS && reg_wdata[`ST_UNDER]) begin
                under_reg <= 1'b0;
            end
            if (dma_valid && en && fifo_full) begin
                over_reg <= 1'b1;
            end else if (reg_wr && reg_addr == `STAT_OFS && reg_wdata[`ST_OVER]) begin
                over_reg <= 1'b0;
            end
        end
    end

    // register images; reserved bits read zero
    always_comb begin
        ctrl_word              = 32'h0000_0000;
        ctrl_word[`CTL_LCD_EN] = ctrl_reg.flat_panel_enable;
        ctrl_word[`CTL_MONO]   = ctrl_reg.panel_monochrome_select;
        ctrl_word[`CTL_TFT]    = ctrl_reg.panel_active_matrix_select;
        ctrl_word[`CTL_VGA_EN] = ctrl_reg.monitor_output_enable;
        ctrl_word[`CTL_SHARE]  = ctrl_reg.dual_fifo_feed_select;
        stat_word              = 32'h0000_0000;
        stat_word[5:0]         = level_reg;
        stat_word[`ST_REQ]     = dma_req;
        stat_word[`ST_UNDER]   = under_reg;
        stat_word[`ST_OVER]    = over_reg;
    end

    // read decode, unmapped offsets answer zero
    always_comb begin
        case (reg_addr)
            `CTRL_OFS: rd_word = ctrl_word;
            `STAT_OFS: rd_word = stat_word;
            default:   rd_word = 32'h0000_0000;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= reg_rd ? rd_word : 32'h0000_0000;
        end
    end
    assign reg_rdata = rdata_reg;

    // dma fifo: a word is dropped only if dma ignores the request level
    assign fifo_full = (level_reg == `LFIFO_DEPTH);
    assign fifo_wr   = dma_valid && en && !fifo_full;
    assign lcd_free  = 6'(`LFIFO_DEPTH - level_reg);
    // shared feed waits for room in both fifos, else lcd room only
    assign dma_req   = en && (lcd_free >= `REQ_WORDS) &&
                       (!share || vga_fifo_free >= `REQ_WORDS);

    always_ff @(posedge core_clk) begin
        if (fifo_wr) begin
            fifo_mem[wr_ptr_reg] <= dma_data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            level_reg  <= '0;
        end else if (!en) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            level_reg  <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + `LFIFO_AW'(fifo_wr);
            rd_ptr_reg <= rd_ptr_reg + `LFIFO_AW'(word_pop);
            level_reg  <= 6'(level_reg + 6'(fifo_wr) - 6'(word_pop));
        end
    end

    // copy of every dma word to the vga fifo while sharing
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            vga_wr_reg   <= 1'b0;
            vga_data_reg <= 32'h0000_0000;
        end else begin
            vga_wr_reg   <= dma_valid && share;
            vga_data_reg <= dma_data;
        end
    end
    assign vga_fifo_wr   = vga_wr_reg;
    assign vga_fifo_data = vga_data_reg;

    // unpack: two 12-bit rgb pixels per word, low half first
    assign head_word    = fifo_mem[rd_ptr_reg];
    assign pix_valid    = en && (level_reg != '0);
    assign pix_fire     = pix_valid && skid_in_ready;
    assign word_pop     = pix_fire && half_reg;
    assign pix_in.r     = half_reg ? head_word[27:24] : head_word[11:8];
    assign pix_in.g     = half_reg ? head_word[23:20] : head_word[7:4];
    assign pix_in.b     = half_reg ? head_word[19:16] : head_word[3:0];
    assign pix_in.phase = ph_reg;

    // dither phase walks across x, y and frames; each pixel sees all 90
    // phases over 90 frames so its long-run duty is exact
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            half_reg   <= 1'b0;
            x_cnt_reg  <= '0;
            y_cnt_reg  <= '0;
            ph_reg     <= '0;
            row_ph_reg <= '0;
            frm_ph_reg <= '0;
        end else if (!en) begin
            half_reg   <= 1'b0;
            x_cnt_reg  <= '0;
            y_cnt_reg  <= '0;
            ph_reg     <= '0;
            row_ph_reg <= '0;
            frm_ph_reg <= '0;
        end else if (pix_fire) begin
            half_reg <= !half_reg;
            if (x_cnt_reg != 10'(`H_ACT - 11'h001)) begin
                x_cnt_reg <= x_cnt_reg + 10'h001;
                ph_reg    <= addm(ph_reg, `DX_STEP);
            end else if (y_cnt_reg != `V_ACT - 10'h001) begin
                x_cnt_reg  <= '0;
                y_cnt_reg  <= y_cnt_reg + 10'h001;
                row_ph_reg <= addm(row_ph_reg, `DY_STEP);
                ph_reg     <= addm(row_ph_reg, `DY_STEP);
            end else begin
                x_cnt_reg  <= '0;
                y_cnt_reg  <= '0;
                frm_ph_reg <= addm(frm_ph_reg, `DF_STEP);
                row_ph_reg <= addm(frm_ph_reg, `DF_STEP);
                ph_reg     <= addm(frm_ph_reg, `DF_STEP);
            end
        end
    end

    function automatic logic [6:0] addm(input logic [6:0] a, input logic [6:0] b);
        logic [7:0] s;
        s = {1'b0, a} + {1'b0, b};
        addm = (s >= `DITH_PERIOD) ? 7'(s - `DITH_PERIOD) : s[6:0];
    endfunction

    lcd_skid u_skid (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .flush     (!en),
        .in_valid  (pix_valid),
        .in_ready  (skid_in_ready),
        .in_pix    (pix_in),
        .out_valid (sk_valid),
        .out_ready (sk_take),
        .out_pix   (sk_pix)
    );

    lcd_dither u_dither (
        .pix  (sk_pix),
        .mono (mono),
        .dots (dots)
    );

    // pixel clock pin from outside: two flops, then edge detect on stage two
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pclk_s1_reg <= 1'b0;
            pclk_s2_reg <= 1'b0;
            pclk_s3_reg <= 1'b0;
        end else begin
            pclk_s1_reg <= pix_clk_in;
            pclk_s2_reg <= pclk_s1_reg;
            pclk_s3_reg <= pclk_s2_reg;
        end
    end
    assign tick = en && pclk_s2_reg && !pclk_s3_reg;

    // line length in units: pixels for tft, dither bits for passive
    assign width      = mono ? 5'h04 : 5'h08;
    assign step       = tft ? 11'h001 : {6'h00, width};
    assign line_units = (tft || mono) ? `H_ACT : 11'(3 * `H_ACT);
    assign v_act      = (v_cnt_reg < `V_ACT);
    assign vsync      = (v_cnt_reg >= `V_ACT + `V_FP) &&
                        (v_cnt_reg <  `V_ACT + `V_FP + `V_SYNC);
    assign in_act     = (h_state_reg == h_act) && v_act;

    // horizontal state and line count, advanced on each pixel clock tick
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            h_state_reg  <= h_act;
            h_cnt_reg    <= '0;
            v_cnt_reg    <= '0;
            frm_bias_reg <= 1'b0;
        end else if (!en) begin
            h_state_reg  <= h_act;
            h_cnt_reg    <= '0;
            v_cnt_reg    <= '0;
        end else if (tick) begin
            case (h_state_reg)
                h_act: begin
                    if (h_cnt_reg + step >= line_units) begin
                        h_state_reg <= h_fp;
                        h_cnt_reg   <= '0;
                    end else begin
                        h_cnt_reg <= h_cnt_reg + step;
                    end
                end
                h_fp: begin
                    h_cnt_reg <= h_cnt_reg + 11'h001;
                    if (h_cnt_reg == `H_FP - 11'h001) begin
                        h_state_reg <= h_sync;
                        h_cnt_reg   <= '0;
                    end
                end
                h_sync: begin
                    h_cnt_reg <= h_cnt_reg + 11'h001;
                    if (h_cnt_reg == `H_SYNC - 11'h001) begin
                        h_state_reg <= h_bp;
                        h_cnt_reg   <= '0;
                    end
                end
                h_bp: begin
                    h_cnt_reg <= h_cnt_reg + 11'h001;
                    if (h_cnt_reg == `H_BP - 11'h001) begin
                        h_state_reg <= h_act;
                        h_cnt_reg   <= '0;
                        if (v_cnt_reg == `V_ACT + `V_FP + `V_SYNC + `V_BP - 10'h001) begin
                            v_cnt_reg    <= '0;
                            frm_bias_reg <= !frm_bias_reg;
                        end else begin
                            v_cnt_reg <= v_cnt_reg + 10'h001;
                        end
                    end
                end
                default: begin
                    h_state_reg <= h_act;
                    h_cnt_reg   <= '0;
                end
            endcase
        end
    end

    // passive packing: dither bits queue lsb first, a tick takes width bits;
    // color gives 8 bits from three-bit pixels, i.e. 2-2/3 pixels per clock
    assign consume   = tick && in_act && !tft;
    assign avail     = (acc_cnt_reg >= width);
    assign after_cnt = (consume && avail) ? acc_cnt_reg - width : acc_cnt_reg;
    assign after_acc = (consume && avail) ? acc_reg >> width : acc_reg;
    assign new_bits  = mono ? {2'b00, dots[2]} : dots;
    assign push      = !tft && en && sk_valid && (after_cnt <= 5'h0D);
    assign sk_take   = tft ? (tick && in_act && sk_valid) : push;
    assign emit_mask = mono ? 8'h0F : 8'hFF;
    assign underrun  = tick && in_act && (tft ? !sk_valid : !avail);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg     <= '0;
            acc_cnt_reg <= '0;
        end else if (!en || tft) begin
            acc_reg     <= '0;
            acc_cnt_reg <= '0;
        end else if (push) begin
            acc_reg     <= after_acc | (16'(new_bits) << after_cnt);
            acc_cnt_reg <= after_cnt + (mono ? 5'h01 : 5'h03);
        end else begin
            acc_reg     <= after_acc;
            acc_cnt_reg <= after_cnt;
        end
    end

    // pin drivers; data changes on the rising tick, panel samples later
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pclk_reg  <= 1'b0;
            line_reg  <= 1'b0;
            frame_reg <= 1'b0;
            bias_reg  <= 1'b0;
        end else begin
            // tft clock runs free while enabled; passive only during data
            pclk_reg  <= en && pclk_s2_reg && (tft || in_act);
            line_reg  <= en && (h_state_reg == h_sync);
            frame_reg <= en && vsync;
            bias_reg  <= en && (tft ? in_act : frm_bias_reg);
        end
    end

    // pixel data; an underrun sends dark rather than stale data
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_reg <= 12'h000;
        end else if (!en) begin
            data_reg <= 12'h000;
        end else if (tick && in_act && tft) begin
            data_reg <= sk_valid ? {sk_pix.r, sk_pix.g, sk_pix.b} : 12'h000;
        end else if (consume) begin
            data_reg <= avail ? {4'h0, acc_reg[7:0] & emit_mask} : 12'h000;
        end
    end

    assign panel_pclk                   = pclk_reg;
    assign panel_line_clk               = line_reg;
    assign panel_frame_clk              = frame_reg;
    assign panel_bias_output_enable_pin = bias_reg;
    assign panel_data                   = data_reg;
endmodule

//--- test/lcd_panel_model.sv
// panel stand-in: latches pixels on pixel clock rises, tallies lit dots
`timescale 1ns/1ps
module lcd_panel_model (
    input  wire logic        core_clk,
    input  wire logic        clr,
    input  wire logic        tft,
    input  wire logic        panel_pclk,
    input  wire logic        panel_bias_output_enable_pin,
    input  wire logic [11:0] panel_data,
    output logic      [15:0] ones,
    output logic      [15:0] caps,
    output logic      [11:0] first_pix
);
    logic pclk_q;
    // sampled on the core clock so clock edge and data never race
    always @(posedge core_clk) begin
        pclk_q <= panel_pclk;
        if (clr) begin
            ones <= '0;
            caps <= '0;
        end else if (panel_pclk && !pclk_q && tft && panel_bias_output_enable_pin) begin
            if (caps == 0)
                first_pix <= panel_data;
            caps <= caps + 16'h0001;
        end else if (panel_pclk && !pclk_q && !tft) begin
            ones <= ones + 16'($countones(panel_data[3:0]));
            caps <= caps + 16'h0004;
        end
    end
endmodule

//--- test/lcd_top_props.sv
// port assertions for the lcd output block
`timescale 1ns/1ps
`include "lcd_params.svh"
module lcd_top_props (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        dma_req,
    input wire logic        dma_valid,
    input wire logic [31:0] dma_data,
    input wire logic [5:0]  vga_fifo_free,
    input wire logic        vga_fifo_wr,
    input wire logic [31:0] vga_fifo_data,
    input wire logic        flat_panel_enable,
    input wire logic        monitor_output_enable,
    input wire logic        pix_clk_in,
    input wire logic        panel_pclk,
    input wire logic        panel_line_clk,
    input wire logic        panel_bias_output_enable_pin
);
    logic [31:0] ctl;
    wire         tft_on = ctl[0] && ctl[4];
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // shadow of the control word, so checks need no internal probes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            ctl <= '0;
        else if (reg_wr && reg_addr == `CTRL_OFS)
            ctl <= reg_wdata;
    end
    sequence pix_rise;
        $rose(pix_clk_in);
    endsequence
    sequence quiet_pins;
        !panel_pclk && !panel_bias_output_enable_pin;
    endsequence
    a_share_room: assert property (
        dma_req && ctl[11] |-> vga_fifo_free >= 6'h08) else $error("request without vga room");
    a_copy_word: assert property (
        dma_valid && ctl[11] |=> vga_fifo_wr && vga_fifo_data == $past(dma_data))
        else $error("shared word not copied");
    a_no_copy: assert property (
        dma_valid && !ctl[11] |=> !vga_fifo_wr) else $error("vga written while unshared");
    a_enable_map: assert property (
        reg_wr && reg_addr == `CTRL_OFS |=> flat_panel_enable == ctl[0]
        && monitor_output_enable == ctl[8]) else $error("enables not from one write");
    a_tft_pclk: assert property (
        tft_on ##0 pix_rise |-> ##[2:6] panel_pclk) else $error("tft pixel clock stalled");
    a_line_quiet: assert property (
        ctl[4] && panel_line_clk |-> !panel_bias_output_enable_pin) else $error("oe in hsync");
    a_off_quiet: assert property (
        !flat_panel_enable |-> !dma_req ##1 quiet_pins) else $error("pins busy while off");
    a_ctrl_read: assert property (
        reg_rd && reg_addr == `CTRL_OFS |=> reg_rdata[4] == ctl[4] && reg_rdata[11] == ctl[11])
        else $error("control readback wrong");
endmodule
bind lcd_top lcd_top_props i_lcd_top_props (.*);

//--- test/tb.sv
// bench: register bus, dma feed, mono dither fractions, tft pixels
`timescale 1ns/1ps
`include "lcd_params.svh"
module tb;
    logic        core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, pix_clk_in = 0;
    logic        dma_valid = 0, clr = 0, tft = 0, got = 0;
    logic [7:0]  reg_addr = '0;
    logic [31:0] reg_wdata = '0, dma_data = '0, seed = 32'h0000_D619, first_word = '0;
    logic [5:0]  vga_fifo_free = '0;
    logic [3:0]  code = '0;
    logic [31:0] reg_rdata, vga_fifo_data;
    logic        dma_req, vga_fifo_wr, flat_panel_enable, monitor_output_enable, panel_pclk;
    logic        panel_line_clk, panel_frame_clk, panel_bias_output_enable_pin;
    logic [11:0] panel_data, first_pix;
    logic [15:0] ones, caps;
    int          err_total = 0, samples_checked = 0;
    lcd_top i_lcd_top (.*);
    lcd_panel_model i_lcd_panel_model (.*);
    always #2 core_clk = ~core_clk;
    // link clock edges land on core falling edges, between rising edges, at a fixed phase
    always #40 pix_clk_in = ~pix_clk_in;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // lit dots of one 640-dot line within ten of the nominal rate
    function automatic logic near(input logic [15:0] n, input logic [3:0] c);
        int thr [16] = '{0, 10, 18, 24, 30, 36, 40, 45, 50, 54, 60, 66, 72, 80, 90, 90};
        int d;
        d = int'(n) * 90 - 640 * thr[c];
        return d >= -900 && d <= 900;
    endfunction
    // dma source answers every request; passive runs: red and green random, blue carries the code; tft runs: all random
    always @(posedge core_clk) begin
        seed          <= xs(seed);
        dma_valid     <= dma_req;
        dma_data      <= tft ? seed & 32'h0FFF_0FFF : {4'h0, seed[7:0], code, 4'h0, seed[15:8], code};
        vga_fifo_free <= seed[21:16];
        if (dma_valid && flat_panel_enable && !got) begin
            first_word <= dma_data;
            got        <= 1;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr    <= 1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_rd   <= 1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 0;
        #1 check(reg_rdata, e);
    endtask
    // disabling flushes, so each mode starts from an empty fifo
    task automatic start(input logic [31:0] c);
        // first pixel tick then lands after the first dma words have reached the fifo
        @(negedge pix_clk_in);
        tft = c[4];
        wr(`CTRL_OFS, 32'h0000_0000);
        clr <= 1;
        got <= 0;
        wr(`CTRL_OFS, c);
        clr <= 0;
    endtask
    task automatic wait_line;
        for (int n = 0; n < 20000 && panel_line_clk !== 1'b1; n++)
            @(posedge core_clk);
        check(32'(panel_line_clk), 32'h0000_0001);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        #400000;
        err_total++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1;
        for (int c = 0; c < 16; c++) begin
            code = 4'(c);
            start(32'h0000_0009);
            wait_line();
            check(32'(near(ones, code)), 32'h0000_0001);
            check(32'(caps), 32'h0000_0280);
        end
        start(32'h0000_0911);
        rd(`CTRL_OFS, 32'h0000_0911);
        rd(8'h08, 32'h0000_0000);
        wait_line();
        check(32'(caps), 32'h0000_0280);
        check(32'(first_pix), 32'(first_word[11:0]));
        summarize();
    end
endmodule
